// ==== hdl/als_fifo_readout_window.sv ====
// Readout window of the ambient-light result queue
`timescale 1ns/10ps

// Contract
// - Eight read-only byte registers from 0xF8 to 0xFF show one queued result.
// - A window byte that is undefined in the current mode reads as zero.
// - Reads below 0xFF leave the window unchanged.
// - A read of 0xFF loads the next queued entry into all eight bytes at once.
// - In a block read the address wraps after 0xFF to a mode-dependent point.
// - Quad modes give blue, green, red, clear as low-first pairs from 0xF8 or bytes from 0xFC.
// - Pair wide mode puts red_blue_sum at 0xFC/0xFD, clear_green_sum at 0xFE/0xFF, low first.
// - Pair byte mode puts red_blue_sum at 0xFE and clear_green_sum at 0xFF as single bytes.
// - With the queue empty the empty flag is set and a read of 0xFF loads zeros into the window.
// - Flush empties the queue and zeroes its pointers but keeps the overflow flag.
// - When the queue is full the overflow flag sets and new results are dropped.
module als_fifo_readout_window import als_window_pkg::*; (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Mode and control bits
  input  wire logic       paired_channel_select,
  input  wire logic       byte_data_select,
  input  wire logic       queue_flush_control,
  // Result stream from the measurement engine
  input  wire logic       result_valid,
  input  wire als_entry_t result_entry,
  output logic            result_ready,
  // Register read port of the serial engine
  input  wire win_read_t  rd_req,
  output logic            rd_valid_reg,
  output logic [7:0]      rd_data_reg,
  output logic [7:0]      rd_next_addr_reg,
  // Status
  output logic            queue_empty_flag,
  output logic            queue_overflow_flag
);

  win_mode_t  mode;
  als_entry_t win_entry_reg;
  logic       win_valid_reg;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic       fifo_full;
  logic       fifo_empty;
  logic       fifo_in_ready;
  logic       in_window;
  logic       top_read;
  logic       win_load;
  logic [2:0] byte_ix;
  logic [7:0] byte_sel;
  logic [7:0] wrap_addr;
  logic       ovf_set;
  logic       ovf_clear;
  logic       ovf_reg;
  logic [ENTRY_W-1:0] fifo_out_data;

  // Mode decode
  always_comb begin
    unique case ({paired_channel_select, byte_data_select})
      2'b00:   mode = MODE_QUAD_WIDE;
      2'b01:   mode = MODE_QUAD_BYTE;
      2'b10:   mode = MODE_PAIR_WIDE;
      2'b11:   mode = MODE_PAIR_BYTE;
    endcase
  end

  assign in_window = rd_req.en && (rd_req.addr >= WIN_BYTE7_ADDR);
  assign top_read  = rd_req.en && (rd_req.addr == WIN_BYTE0_ADDR);
  assign byte_ix   = rd_req.addr[2:0];

  // Byte placement per mode, zero where undefined
  function automatic logic [7:0] window_byte(
    input als_entry_t e,
    input logic [2:0] ix,
    input win_mode_t  m
  );
    logic [15:0] w;
    logic [7:0]  b;
    w = '0;
    b = BYTE_RESET;
    unique case (m)
      MODE_QUAD_WIDE: begin
        unique case (ix[2:1])
          2'b00: w = e.w0;
          2'b01: w = e.w1;
          2'b10: w = e.w2;
          2'b11: w = e.w3;
        endcase
        b = ix[0] ? w[15:8] : w[7:0];
      end
      MODE_QUAD_BYTE: begin
        unique case (ix)
          3'h4:    b = e.w0[7:0];
          3'h5:    b = e.w1[7:0];
          3'h6:    b = e.w2[7:0];
          3'h7:    b = e.w3[7:0];
          default: b = BYTE_RESET;
        endcase
      end
      MODE_PAIR_WIDE: begin
        unique case (ix)
          3'h4:    b = e.w2[7:0];
          3'h5:    b = e.w2[15:8];
          3'h6:    b = e.w3[7:0];
          3'h7:    b = e.w3[15:8];
          default: b = BYTE_RESET;
        endcase
      end
      MODE_PAIR_BYTE: begin
        unique case (ix)
          3'h6:    b = e.w2[7:0];
          3'h7:    b = e.w3[7:0];
          default: b = BYTE_RESET;
        endcase
      end
    endcase
    return b;
  endfunction

  assign byte_sel = window_byte(win_entry_reg, byte_ix, mode);

  // Wrap target for block reads
  always_comb begin
    unique case (mode)
      MODE_QUAD_WIDE: wrap_addr = WRAP_QUAD_WIDE;
      MODE_QUAD_BYTE: wrap_addr = WRAP_QUAD_BYTE;
      MODE_PAIR_WIDE: wrap_addr = WRAP_PAIR_WIDE;
      MODE_PAIR_BYTE: wrap_addr = WRAP_PAIR_BYTE;
    endcase
  end

  // Load on top read, or fill an idle window once data arrives
  assign win_load = !queue_flush_control && (top_read || (!win_valid_reg && fifo_out_valid));
  assign fifo_pop = win_load && fifo_out_valid;

  // Result queue
  als_queue_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (queue_flush_control),
    .in_valid  (result_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (result_entry),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .empty_reg (fifo_empty),
    .full_reg  (fifo_full)
  );

  assign result_ready     = fifo_in_ready;
  assign queue_empty_flag = fifo_empty;

  // Window entry
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      win_entry_reg <= '0;
      win_valid_reg <= 1'b0;
    end else if (queue_flush_control) begin
      win_entry_reg <= '0;
      win_valid_reg <= 1'b0;
    end else if (win_load) begin
      win_entry_reg <= fifo_out_valid ? als_entry_t'(fifo_out_data) : '0;
      win_valid_reg <= fifo_out_valid;
    end
  end

  // Read answer and next block-read address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_reg     <= 1'b0;
      rd_data_reg      <= BYTE_RESET;
      rd_next_addr_reg <= WIN_BYTE7_ADDR;
    end else begin
      rd_valid_reg <= rd_req.en;
      if (rd_req.en) begin
        rd_data_reg      <= in_window ? byte_sel : BYTE_RESET;
        rd_next_addr_reg <= top_read ? wrap_addr : 8'(rd_req.addr + 1'b1);
      end
    end
  end

  // Overflow flag; set wins over the dummy-read clear
  assign ovf_set   = result_valid && fifo_full;
  assign ovf_clear = in_window;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_reg <= 1'b0;
    end else if (ovf_set) begin
      ovf_reg <= 1'b1;
    end else if (ovf_clear) begin
      ovf_reg <= 1'b0;
    end
  end

  assign queue_overflow_flag = ovf_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_range_answer: assert property (
    rd_req.en && !in_window |=> rd_valid_reg && (rd_data_reg == BYTE_RESET))
    else $error("read outside window gave data");

  a_undef_low_zero: assert property (
    rd_req.en && in_window && (byte_ix < FIRST_UPPER_IX) && (mode != MODE_QUAD_WIDE)
    |=> rd_data_reg == BYTE_RESET)
    else $error("undefined low byte not zero");

  a_pair_byte_zero: assert property (
    rd_req.en && in_window && (mode == MODE_PAIR_BYTE) && (byte_ix < PAIR_BYTE_LO)
    |=> rd_data_reg == BYTE_RESET)
    else $error("undefined pair byte not zero");

  a_hold_low_read: assert property (
    rd_req.en && in_window && !top_read && win_valid_reg && !queue_flush_control
    |=> $stable(win_entry_reg))
    else $error("window changed on low read");

  a_advance_top: assert property (
    top_read && fifo_out_valid && !queue_flush_control
    |=> win_entry_reg == $past(fifo_out_data))
    else $error("top read did not load next entry");

  a_empty_top_zero: assert property (
    top_read && !fifo_out_valid && !queue_flush_control |=> win_entry_reg == '0)
    else $error("empty load not zero");

  a_wrap_point: assert property (
    top_read |=> rd_next_addr_reg == $past(wrap_addr))
    else $error("wrap address wrong");

  a_wrap_quad_wide: assert property (
    top_read && (mode == MODE_QUAD_WIDE) |=> rd_next_addr_reg == 8'hf8)
    else $error("quad wide wrap not at lowest");

  a_wrap_pair_byte: assert property (
    top_read && (mode == MODE_PAIR_BYTE) |=> rd_next_addr_reg == 8'hfe)
    else $error("pair byte wrap wrong");

  a_incr_addr: assert property (
    rd_req.en && !top_read |=> rd_next_addr_reg == $past(rd_req.addr) + 8'h01)
    else $error("address did not advance");

  a_quad_wide_lo: assert property (
    rd_req.en && (rd_req.addr == WIN_BYTE7_ADDR) && (mode == MODE_QUAD_WIDE)
    |=> rd_data_reg == $past(win_entry_reg[7:0]))
    else $error("blue low byte misplaced");

  a_quad_byte_clr: assert property (
    top_read && (mode == MODE_QUAD_BYTE) |=> rd_data_reg == $past(win_entry_reg[55:48]))
    else $error("clear byte misplaced");

  a_pair_wide_hi: assert property (
    rd_req.en && (rd_req.addr == WIN_BYTE2_ADDR) && (mode == MODE_PAIR_WIDE)
    |=> rd_data_reg == $past(win_entry_reg[47:40]))
    else $error("red_blue_sum high byte misplaced");

  a_pair_byte_rb: assert property (
    rd_req.en && (rd_req.addr == WIN_BYTE1_ADDR) && (mode == MODE_PAIR_BYTE)
    |=> rd_data_reg == $past(win_entry_reg[39:32]))
    else $error("red_blue_sum byte misplaced");

  a_empty_flag: assert property (
    queue_empty_flag && !(result_valid && result_ready) |=> queue_empty_flag)
    else $error("empty flag dropped without a result");

  a_flush_empties: assert property (
    queue_flush_control |=> queue_empty_flag && !win_valid_reg && (win_entry_reg == '0))
    else $error("flush did not empty queue");

  a_flush_keeps_ovf: assert property (
    queue_overflow_flag && queue_flush_control && !in_window |=> queue_overflow_flag)
    else $error("flush cleared overflow");

  a_ovf_on_full: assert property (
    result_valid && fifo_full |=> queue_overflow_flag)
    else $error("overflow not set when full");

  a_drop_full: assert property (
    fifo_full && !fifo_pop && !queue_flush_control |=> fifo_full)
    else $error("full queue accepted data");

  a_dummy_clear: assert property (
    in_window && !ovf_set |=> !queue_overflow_flag)
    else $error("dummy read did not clear overflow");

endmodule

// ==== pkg/als_window_pkg.sv ====
// Constants and types for the ambient-light result readout window
package als_window_pkg;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int SAMPLE_W   = 16;
  localparam int ENTRY_W    = 64;

  // Window register addresses
  localparam logic [7:0] WIN_BYTE7_ADDR = 8'hf8;
  localparam logic [7:0] WIN_BYTE6_ADDR = 8'hf9;
  localparam logic [7:0] WIN_BYTE5_ADDR = 8'hfa;
  localparam logic [7:0] WIN_BYTE4_ADDR = 8'hfb;
  localparam logic [7:0] WIN_BYTE3_ADDR = 8'hfc;
  localparam logic [7:0] WIN_BYTE2_ADDR = 8'hfd;
  localparam logic [7:0] WIN_BYTE1_ADDR = 8'hfe;
  localparam logic [7:0] WIN_BYTE0_ADDR = 8'hff;

  // Block-read wrap targets per mode
  localparam logic [7:0] WRAP_QUAD_WIDE = 8'hf8;
  localparam logic [7:0] WRAP_QUAD_BYTE = 8'hfc;
  localparam logic [7:0] WRAP_PAIR_WIDE = 8'hfc;
  localparam logic [7:0] WRAP_PAIR_BYTE = 8'hfe;

  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [2:0] FIRST_UPPER_IX = 3'h4;
  localparam logic [2:0] PAIR_BYTE_LO   = 3'h6;

  typedef enum logic [1:0] {
    MODE_QUAD_WIDE,
    MODE_QUAD_BYTE,
    MODE_PAIR_WIDE,
    MODE_PAIR_BYTE
  } win_mode_t;

  // One queued result; quad mode: w0 blue, w1 green, w2 red, w3 clear.
  // Pair mode: w2 red_blue_sum, w3 clear_green_sum. Byte data in low bits.
  typedef struct packed {
    logic [SAMPLE_W-1:0] w3;
    logic [SAMPLE_W-1:0] w2;
    logic [SAMPLE_W-1:0] w1;
    logic [SAMPLE_W-1:0] w0;
  } als_entry_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
  } win_read_t;

endpackage

// ==== hdl/als_queue_mem.sv ====
// Storage array of the result queue with registered read data
`timescale 1ns/10ps
module als_queue_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic             core_clk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Write bypass so a fresh word is seen at once
  always_ff @(posedge core_clk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule

// ==== hdl/als_queue_fifo.sv ====
// Result queue with valid/ready on both sides and a flush input
`timescale 1ns/10ps
module als_queue_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Status
  output logic                  empty_reg,
  output logic                  full_reg
);

  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          push;
  logic          pop;
  logic [AW-1:0] rd_addr_next;

  assign push         = in_valid && !full_reg;
  assign pop          = out_ready && !empty_reg;
  assign out_valid    = !empty_reg;
  assign rd_addr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = (AW+1)'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = (AW+1)'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      empty_reg  <= 1'b1;
      full_reg   <= 1'b0;
      in_ready   <= 1'b1;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      empty_reg  <= 1'b1;
      full_reg   <= 1'b0;
      in_ready   <= 1'b1;
    end else begin
      wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= rd_addr_next;
      count_reg  <= count_next;
      empty_reg  <= (count_next == '0);
      full_reg   <= (count_next == (AW+1)'(DEPTH));
      in_ready   <= (count_next != (AW+1)'(DEPTH));
    end
  end

  als_queue_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .core_clk (core_clk),
    .wr_en    (push && !flush),
    .wr_addr  (wr_ptr_reg),
    .wr_data  (in_data),
    .rd_addr  (flush ? AW'(0) : rd_addr_next),
    .rd_data  (out_data)
  );

endmodule

// ==== test/als_host_model.sv ====
// Host model issuing register reads to the result readout window
`timescale 1ns/10ps
module als_host_model
  import als_window_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Read port
  output win_read_t       rd_req,
  input  wire logic       rd_valid_reg,
  input  wire logic [7:0] rd_data_reg,
  input  wire logic [7:0] rd_next_addr_reg
);
  initial rd_req = '{en: 1'b0, addr: 8'h00};

  // One read; address released to its inverse after the taking edge
  task automatic read(input logic [7:0] a, output logic v, output logic [7:0] d,
                      output logic [7:0] n);
    @(posedge core_clk);
    rd_req <= '{en: 1'b1, addr: a};
    @(posedge core_clk);
    rd_req <= '{en: 1'b0, addr: ~a};
    #1;
    v = rd_valid_reg;
    d = rd_data_reg;
    n = rd_next_addr_reg;
  endtask

  // Block read of eight bytes following the returned next address
  task automatic block_read(input logic [7:0] start, output logic [7:0] d [8],
                            output logic [7:0] n, output logic vall);
    logic       v;
    logic [7:0] a;
    a = start;
    vall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      read(a, v, d[i], n);
      vall = vall & v;
      a = n;
    end
  endtask
endmodule

// ==== test/tb_als_fifo_readout_window.sv ====
// Self-checking bench of the result readout window
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_als_fifo_readout_window
  import als_window_pkg::*;
;
  logic       core_clk;
  logic       nrst;
  logic       paired_channel_select;
  logic       byte_data_select;
  logic       queue_flush_control;
  logic       result_valid;
  als_entry_t result_entry;
  logic       result_ready;
  win_read_t  rd_req;
  logic       rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_next_addr_reg;
  logic       queue_empty_flag;
  logic       queue_overflow_flag;
  int         miscompares;
  int         num_checks;
  int         cycles;
  logic [7:0] wrap_tab [4] = '{8'hf8, 8'hfc, 8'hfc, 8'hfe};

  als_fifo_readout_window als_fifo_readout_window_inst (
    .core_clk(core_clk), .nrst(nrst), .paired_channel_select(paired_channel_select),
    .byte_data_select(byte_data_select), .queue_flush_control(queue_flush_control),
    .result_valid(result_valid), .result_entry(result_entry), .result_ready(result_ready),
    .rd_req(rd_req), .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg),
    .rd_next_addr_reg(rd_next_addr_reg), .queue_empty_flag(queue_empty_flag),
    .queue_overflow_flag(queue_overflow_flag));

  als_host_model als_host_model_inst (
    .core_clk(core_clk), .rd_req(rd_req), .rd_valid_reg(rd_valid_reg),
    .rd_data_reg(rd_data_reg), .rd_next_addr_reg(rd_next_addr_reg));

  always #50 core_clk = ~core_clk;

  function automatic als_entry_t mk(input logic [7:0] k);
    mk = {8'hd3, 8'(k + 8'h03), 8'hc2, 8'(k + 8'h02), 8'hb1, 8'(k + 8'h01), 8'ha0, k};
  endfunction

  // Expected byte at window index ix for mode {pair, byte}
  function automatic logic [7:0] exp_byte(input als_entry_t e, input int ix,
                                          input logic [1:0] m);
    logic [15:0] w [4];
    w = '{e.w0, e.w1, e.w2, e.w3};
    case (m)
      2'b00: return ix[0] ? w[ix/2][15:8] : w[ix/2][7:0];
      2'b01: return (ix >= 4) ? w[ix-4][7:0] : 8'h00;
      2'b10: return (ix >= 4) ? (ix[0] ? w[ix/2][15:8] : w[ix/2][7:0]) : 8'h00;
      default: return (ix >= 6) ? w[ix-4][7:0] : 8'h00;
    endcase
  endfunction

  task automatic push(input als_entry_t e);
    @(posedge core_clk);
    result_valid <= 1'b1;
    result_entry <= e;
    @(posedge core_clk);
    result_valid <= 1'b0;
    result_entry <= ~e;
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge core_clk);
    {paired_channel_select, byte_data_select} <= m;
  endtask

  task automatic t_reset();
    logic [7:0] d [8];
    logic [7:0] n;
    logic       v;
    `CHK(queue_empty_flag, 1'b1)
    `CHK(queue_overflow_flag, 1'b0)
    `CHK(result_ready, 1'b1)
    als_host_model_inst.read(8'hf7, v, d[0], n);
    `CHK(d[0], 8'h00)
    `CHK(n, 8'hf8)
    als_host_model_inst.block_read(8'hf8, d, n, v);
    for (int i = 0; i < 8; i++) `CHK(d[i], 8'h00)
    `CHK(v, 1'b1)
    `CHK(n, 8'hf8)
  endtask

  task automatic t_modes();
    logic [7:0] d [8];
    logic [7:0] n;
    logic       v;
    als_entry_t e;
    for (int m = 0; m < 4; m++) begin
      e = mk(8'(8'h10 * m));
      set_mode(2'(m));
      push(e);
      repeat (3) @(posedge core_clk);
      als_host_model_inst.block_read(8'hf8, d, n, v);
      for (int i = 0; i < 8; i++) `CHK(d[i], exp_byte(e, i, 2'(m)))
      `CHK(n, wrap_tab[m])
      `CHK(v, 1'b1)
    end
  endtask

  task automatic t_advance();
    logic [7:0] d;
    logic [7:0] n;
    logic       v;
    set_mode(2'b00);
    push(mk(8'h01));
    push(mk(8'h02));
    repeat (3) @(posedge core_clk);
    repeat (2) begin
      als_host_model_inst.read(8'hf8, v, d, n);
      `CHK(d, exp_byte(mk(8'h01), 0, 2'b00))
    end
    als_host_model_inst.read(8'hff, v, d, n);
    `CHK(d, exp_byte(mk(8'h01), 7, 2'b00))
    als_host_model_inst.read(8'hfa, v, d, n);
    `CHK(d, exp_byte(mk(8'h02), 2, 2'b00))
    als_host_model_inst.read(8'hff, v, d, n);
    als_host_model_inst.read(8'hf9, v, d, n);
    `CHK(d, 8'h00)
    `CHK(queue_empty_flag, 1'b1)
  endtask

  task automatic t_overflow();
    logic [7:0] d;
    logic [7:0] n;
    logic       v;
    for (int i = 0; i < 20; i++) push(mk(8'(i)));
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(result_ready, 1'b0)
    `CHK(queue_overflow_flag, 1'b1)
    @(posedge core_clk);
    queue_flush_control <= 1'b1;
    @(posedge core_clk);
    queue_flush_control <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(queue_empty_flag, 1'b1)
    `CHK(queue_overflow_flag, 1'b1)
    als_host_model_inst.read(8'hf8, v, d, n);
    `CHK(d, 8'h00)
    @(posedge core_clk);
    #1;
    `CHK(queue_overflow_flag, 1'b0)
    push(mk(8'h40));
    repeat (3) @(posedge core_clk);
    als_host_model_inst.read(8'hfa, v, d, n);
    `CHK(d, exp_byte(mk(8'h40), 2, 2'b00))
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    paired_channel_select = 1'b0;
    byte_data_select = 1'b0;
    queue_flush_control = 1'b0;
    result_valid = 1'b0;
    result_entry = '0;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset();
    t_modes();
    t_advance();
    t_overflow();
    summarize();
  end
endmodule
